// ### sdc_cfg_host.sv
// Model of the loader or SMBus host that writes and reads the bank.
// Assumes the bench calls its tasks; strobes move on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module sdc_cfg_host (
	input wire logic clk_i,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o
);
	// Idle bus at time zero
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// Released data shows the inverse so a stale value never looks fresh
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		wr_o = 1'b1;
		addr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		wr_o = 1'b0;
		wdata_o = ~d;
	endtask
	task automatic get(input logic [7:0] a);
		@(negedge clk_i);
		rd_o = 1'b1;
		addr_o = a;
		@(negedge clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
	endtask
endmodule
`default_nettype wire

// ### sdc_pkg.sv
// Package for the string descriptor configuration register bank.
// Assumes an 8-bit register port driven by the hub's EEPROM loader or SMBus slave.
package sdc_pkg;
	localparam logic [7:0] SDC_OFF_LANG_LO = 8'h20;
	localparam logic [7:0] SDC_OFF_LANG_HI = 8'h21;
	localparam logic [7:0] SDC_OFF_SER_LEN = 8'h22;
	localparam logic [7:0] SDC_OFF_MAK_LEN = 8'h23;
	localparam logic [7:0] SDC_OFF_ITM_LEN = 8'h24;
	localparam logic [7:0] SDC_OFF_SER_FIRST = 8'h30;
	localparam logic [7:0] SDC_OFF_SER_LAST = 8'h4F;
	localparam logic [7:0] SDC_RST_LANG_LO = 8'h09;
	localparam logic [7:0] SDC_RST_LANG_HI = 8'h04;
	localparam logic [5:0] SDC_RST_SER_LEN = 6'h18;
	localparam logic [6:0] SDC_RST_MAK_LEN = 7'h00;
	localparam logic [6:0] SDC_RST_ITM_LEN = 7'h00;
	localparam int SDC_SER_LEN_W = 6;
	localparam int SDC_TXT_LEN_W = 7;
	localparam logic [6:0] SDC_SER_MAX = 7'h20;
	localparam logic [7:0] SDC_TXT_MAX = 8'h40;
	localparam logic [7:0] SDC_IDX_LANG = 8'h00;
	localparam logic [7:0] SDC_IDX_SER = 8'h01;
	localparam logic [7:0] SDC_IDX_ITM = 8'h02;
	localparam logic [7:0] SDC_IDX_MAK = 8'h03;
	localparam logic [7:0] SDC_SER_RST_BYTE = 8'h30;
	typedef enum logic [1:0] {SDC_SRC_NONE, SDC_SRC_SER, SDC_SRC_MAK, SDC_SRC_ITM} sdc_src_t;
endpackage

// ### sdc_regs_checker.sv
// Checker for the string descriptor register bank ports.
// Assumes it is bound to sdc_string_descriptor_regs.
`timescale 1ns/100ps
`default_nettype none
module sdc_regs_checker (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic desc_req_i,
	input wire logic [7:0] desc_index_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic desc_valid_o,
	input wire logic desc_present_o,
	input wire logic [6:0] desc_len_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	// Lookup answers come exactly one cycle after the request
	desc_answer_a: assert property (desc_req_i |=> desc_valid_o) else $error("no answer");
	valid_cause_a: assert property (desc_valid_o |-> $past(desc_req_i)) else $error("stray answer");
	lang_len_a: assert property (desc_req_i && desc_index_i == 8'h00 |=> desc_present_o && desc_len_o == 7'h02)
		else $error("bad index zero");
	ser_max_a: assert property (desc_req_i && desc_index_i == 8'h01 |=> desc_len_o <= 7'h20)
		else $error("serial too long");
	txt_max_a: assert property (desc_req_i && desc_index_i inside {8'h02, 8'h03} |=> desc_len_o <= 7'h40)
		else $error("text too long");
	present_len_a: assert property (desc_valid_o |-> desc_present_o == (desc_len_o != 7'h00))
		else $error("present flag wrong");
	// Reserved bits never reach the read port
	ser_rsvd_a: assert property (reg_rd_i && reg_addr_i == 8'h22 |=> reg_rdata_o[7:6] == 2'h0)
		else $error("serial reserved set");
	txt_rsvd_a: assert property (reg_rd_i && reg_addr_i inside {8'h23, 8'h24} |=> !reg_rdata_o[7])
		else $error("text reserved set");
	ser_field_a: assert property (reg_rd_i && reg_addr_i == 8'h22 |=> reg_rdata_o <= 8'h20)
		else $error("serial field too big");
endmodule
bind sdc_string_descriptor_regs sdc_regs_checker chk (.ref_clk_i, .nrst_i, .reg_rd_i, .reg_addr_i, .desc_req_i,
	.desc_index_i, .reg_rdata_o, .desc_valid_o, .desc_present_o, .desc_len_o);
`default_nettype wire

// ### sdc_string_descriptor_regs.sv
// String descriptor configuration registers: language ID, string lengths, serial bytes.
// Assumes one clock; reg_wr_i/reg_rd_i come from on-chip loader logic on the same clock.
// Operation
// - Language high byte resets to 04h
// - Index zero reports high byte as upper
// - Text override unlocks language bytes, maker and item lengths
// - Serial length bits 5:0, reset 18h
// - Serial length limited to 32 bytes
// - Serial override unlocks serial length field
// - Index 1 serves serial length bytes
// - Maker length bits 6:0, reset zero
// - Maker, item lengths limited 64 bytes
// - Index 3 serves maker length bytes
// - Item length bits 6:0, reset zero
// - Index 2 serves item length bytes
// - Reserved bits ignore writes, read zero
// - Language low byte resets to 09h
// - Serial bytes live at 30h to 4Fh
`timescale 1ns/100ps
`default_nettype none
module sdc_string_descriptor_regs
	import sdc_pkg::*;
#(
	parameter int SER_BYTES = 32
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic custom_text_override_i,
	input wire logic custom_serial_override_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic desc_req_i,
	input wire logic [7:0] desc_index_i,
	input wire logic [5:0] desc_byte_i,
	output logic [7:0] reg_rdata_o,
	output logic desc_valid_o,
	output logic desc_present_o,
	output logic [6:0] desc_len_o,
	output logic [7:0] desc_data_o,
	output logic [15:0] lang_id_o
);
	initial begin
		if (SER_BYTES != 32) begin
			$error("SER_BYTES must span 30h..4Fh, i.e. 32");
		end
	end

	logic [7:0] lang_lo_ff;
	logic [7:0] language_id_high_byte_ff;
	logic [5:0] serial_string_length_ff;
	logic [6:0] maker_string_length_ff;
	logic [6:0] item_string_length_ff;
	logic [7:0] ser_mem_ff [SER_BYTES];
	logic [7:0] reg_rdata_ff;
	logic desc_valid_ff;
	logic desc_present_ff;
	logic [6:0] desc_len_ff;
	logic [7:0] desc_data_ff;
	logic [7:0] nxt_rdata;
	logic ser_hit;
	logic [4:0] ser_widx;

	// Decode of the serial data window, used for both reads and writes
	function automatic logic in_ser(input logic [7:0] a);
		in_ser = (a >= SDC_OFF_SER_FIRST) && (a <= SDC_OFF_SER_LAST);
	endfunction

	assign ser_hit = in_ser(reg_addr_i);
	assign ser_widx = 5'(reg_addr_i - SDC_OFF_SER_FIRST);

	// Language bytes; both bytes locked unless text override is on
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lang_lo_ff <= SDC_RST_LANG_LO;
			language_id_high_byte_ff <= SDC_RST_LANG_HI;
		end else if (reg_wr_i && custom_text_override_i) begin
			if (reg_addr_i == SDC_OFF_LANG_LO) begin
				lang_lo_ff <= reg_wdata_i;
			end
			if (reg_addr_i == SDC_OFF_LANG_HI) begin
				language_id_high_byte_ff <= reg_wdata_i;
			end
		end
	end

	// Serial length; writes past 32 bytes are refused so the field stays servable
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			serial_string_length_ff <= SDC_RST_SER_LEN;
		end else if (reg_wr_i && custom_serial_override_i && reg_addr_i == SDC_OFF_SER_LEN) begin
			if ({1'b0, reg_wdata_i[5:0]} <= SDC_SER_MAX) begin
				serial_string_length_ff <= reg_wdata_i[5:0];
			end
		end
	end

	// Maker and item lengths; writes past 64 bytes are refused, not clamped
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			maker_string_length_ff <= SDC_RST_MAK_LEN;
			item_string_length_ff <= SDC_RST_ITM_LEN;
		end else if (reg_wr_i && custom_text_override_i
			&& {1'b0, reg_wdata_i[6:0]} <= SDC_TXT_MAX) begin
			if (reg_addr_i == SDC_OFF_MAK_LEN) begin
				maker_string_length_ff <= reg_wdata_i[6:0];
			end
			if (reg_addr_i == SDC_OFF_ITM_LEN) begin
				item_string_length_ff <= reg_wdata_i[6:0];
			end
		end
	end

	// Serial data bytes, one flop row each; writable only under serial override
	generate
		for (genvar g = 0; g < SER_BYTES; g++) begin : g_ser
			always_ff @(posedge ref_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					ser_mem_ff[g] <= SDC_SER_RST_BYTE;
				end else if (reg_wr_i && custom_serial_override_i && ser_hit && ser_widx == 5'(g)) begin
					ser_mem_ff[g] <= reg_wdata_i;
				end
			end
		end
	endgenerate

	// Read mux; reserved bits and unmapped offsets return zero
	always_comb begin
		nxt_rdata = 8'h00;
		if (ser_hit) begin
			nxt_rdata = ser_mem_ff[ser_widx];
		end else begin
			case (reg_addr_i)
				SDC_OFF_LANG_LO: nxt_rdata = lang_lo_ff;
				SDC_OFF_LANG_HI: nxt_rdata = language_id_high_byte_ff;
				SDC_OFF_SER_LEN: nxt_rdata = {2'b00, serial_string_length_ff};
				SDC_OFF_MAK_LEN: nxt_rdata = {1'b0, maker_string_length_ff};
				SDC_OFF_ITM_LEN: nxt_rdata = {1'b0, item_string_length_ff};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// Read data registered one cycle after the strobe and held until the next read
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_ff <= 8'h00;
		end else if (reg_rd_i) begin
			reg_rdata_ff <= nxt_rdata;
		end
	end

	// Descriptor lookup: presence, length and one data byte per request.
	// Maker and item byte stores sit outside this bank, so only their length is answered here.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			desc_valid_ff <= 1'b0;
			desc_present_ff <= 1'b0;
			desc_len_ff <= 7'h00;
			desc_data_ff <= 8'h00;
		end else begin
			desc_valid_ff <= desc_req_i;
			if (desc_req_i) begin
				desc_present_ff <= 1'b0;
				desc_len_ff <= 7'h00;
				desc_data_ff <= 8'h00;
				case (desc_index_i)
					SDC_IDX_LANG: begin
						desc_present_ff <= 1'b1;
						desc_len_ff <= 7'h02;
						desc_data_ff <= desc_byte_i[0] ? language_id_high_byte_ff : lang_lo_ff;
					end
					SDC_IDX_SER: begin
						desc_present_ff <= (serial_string_length_ff != 6'h00);
						desc_len_ff <= {1'b0, serial_string_length_ff};
						if (desc_byte_i < serial_string_length_ff) begin
							desc_data_ff <= ser_mem_ff[desc_byte_i[4:0]];
						end
					end
					SDC_IDX_ITM: begin
						desc_present_ff <= (item_string_length_ff != 7'h00);
						desc_len_ff <= item_string_length_ff;
					end
					SDC_IDX_MAK: begin
						desc_present_ff <= (maker_string_length_ff != 7'h00);
						desc_len_ff <= maker_string_length_ff;
					end
					default: desc_present_ff <= 1'b0;
				endcase
			end
		end
	end

	// Language code as one word, registered
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lang_id_o <= {SDC_RST_LANG_HI, SDC_RST_LANG_LO};
		end else begin
			lang_id_o <= {language_id_high_byte_ff, lang_lo_ff};
		end
	end

	assign reg_rdata_o = reg_rdata_ff;
	assign desc_valid_o = desc_valid_ff;
	assign desc_present_o = desc_present_ff;
	assign desc_len_o = desc_len_ff;
	assign desc_data_o = desc_data_ff;
endmodule
`default_nettype wire

// ### sdc_string_descriptor_regs_tb.sv
// Bench for the string descriptor register bank.
// Assumes sdc_cfg_host drives the register port; the bench drives overrides and lookups.
`timescale 1ns/100ps
`default_nettype none
module sdc_string_descriptor_regs_tb;
	import sdc_pkg::*;
	logic ref_clk_i, nrst_i, txt_ovr, ser_ovr, wr, rd, req, dvalid, dpres;
	logic [7:0] addr, wdata, idx, rdata, ddata;
	logic [5:0] byt;
	logic [6:0] dlen;
	logic [15:0] lang;
	int err_total, samples_checked;
	sdc_cfg_host host (.clk_i(ref_clk_i), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
	sdc_string_descriptor_regs #(.SER_BYTES(32)) DUT (.ref_clk_i, .nrst_i, .custom_text_override_i(txt_ovr),
		.custom_serial_override_i(ser_ovr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.desc_req_i(req), .desc_index_i(idx), .desc_byte_i(byt), .reg_rdata_o(rdata), .desc_valid_o(dvalid),
		.desc_present_o(dpres), .desc_len_o(dlen), .desc_data_o(ddata), .lang_id_o(lang));
	// 50 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		host.get(a);
		chk("register", {8'h00, e}, {8'h00, rdata});
	endtask
	// Answer is sampled at the falling edge after the taking edge
	task automatic desc_chk(input logic [7:0] i, input logic [5:0] b, input logic p, input logic [6:0] l,
		input logic [7:0] d);
		@(negedge ref_clk_i);
		req = 1'b1;
		idx = i;
		byt = b;
		@(negedge ref_clk_i);
		req = 1'b0;
		chk("valid", 16'h0001, {15'h0000, dvalid});
		chk("present", {15'h0000, p}, {15'h0000, dpres});
		chk("length", {9'h000, l}, {9'h000, dlen});
		chk("data", {8'h00, d}, {8'h00, ddata});
	endtask
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Watchdog far beyond the few microseconds the tests need
	initial begin
		#50000;
		err_total++;
		wrap_up();
	end
	initial begin
		{txt_ovr, ser_ovr, req, nrst_i} = 4'h0;
		idx = 8'h00;
		byt = 6'h00;
		repeat (2) @(negedge ref_clk_i);
		nrst_i = 1'b1;
		// First pass checks reset values, second that locked writes left them alone
		for (int k = 0; k < 2; k++) begin
			rd_chk(SDC_OFF_LANG_LO, 8'h09);
			rd_chk(SDC_OFF_LANG_HI, 8'h04);
			rd_chk(SDC_OFF_SER_LEN, 8'h18);
			rd_chk(SDC_OFF_MAK_LEN, 8'h00);
			rd_chk(SDC_OFF_ITM_LEN, 8'h00);
			host.put(SDC_OFF_LANG_HI, 8'h3C);
			host.put(SDC_OFF_SER_LEN, 8'h05);
			host.put(SDC_OFF_MAK_LEN, 8'h05);
		end
		chk("lang id", 16'h0409, lang);
		rd_chk(SDC_OFF_SER_FIRST, SDC_SER_RST_BYTE);
		rd_chk(8'hF0, 8'h00);
		desc_chk(SDC_IDX_LANG, 6'h00, 1'b1, 7'h02, 8'h09);
		desc_chk(SDC_IDX_LANG, 6'h01, 1'b1, 7'h02, 8'h04);
		desc_chk(SDC_IDX_SER, 6'h00, 1'b1, 7'h18, SDC_SER_RST_BYTE);
		desc_chk(SDC_IDX_MAK, 6'h00, 1'b0, 7'h00, 8'h00);
		desc_chk(SDC_IDX_ITM, 6'h00, 1'b0, 7'h00, 8'h00);
		// Text unlocked: 64 is the largest length, reserved bit dropped
		txt_ovr = 1'b1;
		host.put(SDC_OFF_LANG_HI, 8'hAB);
		host.put(SDC_OFF_MAK_LEN, 8'hC0);
		host.put(SDC_OFF_ITM_LEN, 8'h8A);
		host.put(SDC_OFF_ITM_LEN, 8'h41);
		rd_chk(SDC_OFF_LANG_HI, 8'hAB);
		rd_chk(SDC_OFF_MAK_LEN, 8'h40);
		rd_chk(SDC_OFF_ITM_LEN, 8'h0A);
		chk("lang id", 16'hAB09, lang);
		desc_chk(SDC_IDX_LANG, 6'h01, 1'b1, 7'h02, 8'hAB);
		desc_chk(SDC_IDX_MAK, 6'h00, 1'b1, 7'h40, 8'h00);
		desc_chk(SDC_IDX_ITM, 6'h00, 1'b1, 7'h0A, 8'h00);
		// Serial data stays locked until the serial override is raised
		host.put(SDC_OFF_SER_FIRST, 8'h77);
		rd_chk(SDC_OFF_SER_FIRST, SDC_SER_RST_BYTE);
		// Serial unlocked: 32 taken, 33 dropped, last data byte served
		ser_ovr = 1'b1;
		host.put(SDC_OFF_SER_LEN, 8'hE0);
		host.put(SDC_OFF_SER_LEN, 8'h21);
		host.put(SDC_OFF_SER_LAST, 8'h5A);
		rd_chk(SDC_OFF_SER_LEN, 8'h20);
		desc_chk(SDC_IDX_SER, 6'h1F, 1'b1, 7'h20, 8'h5A);
		wrap_up();
	end
endmodule
`default_nettype wire
